// file: inc/cgc_pkg.sv
// Purpose: Constants and types for the clock generator control registers
// Assumes: 8-bit register port, one clock domain
// Notes: Offsets are local choices; no printed offsets exist
package cgc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [2:0] CGC_ADDR_CTRL_ONE = 3'h0;
  localparam logic [2:0] CGC_ADDR_CTRL_TWO = 3'h1;
  localparam logic [2:0] CGC_ADDR_STATUS = 3'h2;
  localparam logic [2:0] CGC_ADDR_FLAGS = 3'h3;

  // ----------------------------------------------------------------
  // Control one fields
  // ----------------------------------------------------------------
  localparam int CGC_C1_HGO = 7;
  localparam int CGC_C1_RANGE = 6;
  localparam int CGC_C1_REF = 5;
  localparam int CGC_C1_MODE_HI = 4;
  localparam int CGC_C1_MODE_LO = 3;
  localparam int CGC_C1_OSCOFF = 2;
  localparam int CGC_C1_CLOCK_LOSS_DETECT_DISABLE = 1;

  // ----------------------------------------------------------------
  // Control two fields
  // ----------------------------------------------------------------
  localparam int CGC_C2_LOCK_LOSS_RESET_ENABLE = 7;
  localparam int CGC_C2_MFD_HI = 6;
  localparam int CGC_C2_MFD_LO = 4;
  localparam int CGC_C2_CLOCK_LOSS_RESET_ENABLE = 3;
  localparam int CGC_C2_RFD_HI = 2;
  localparam int CGC_C2_RFD_LO = 0;

  // ----------------------------------------------------------------
  // Flags register fields (write 1 to clear)
  // ----------------------------------------------------------------
  localparam int CGC_FL_LOCK_LOSS_STICKY_FLAG = 0;
  localparam int CGC_FL_LOCS = 1;

  // ----------------------------------------------------------------
  // Reset values and codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CGC_C1_RESET = 8'h00;
  localparam logic [7:0] CGC_C2_RESET = 8'h00;
  localparam logic [7:0] CGC_PRESCALE_LOW = 8'h40;
  localparam logic [7:0] CGC_PRESCALE_HIGH = 8'h01;
  localparam logic [4:0] CGC_MULT_BASE = 5'h04;
  localparam int CGC_UPDATE_CYCLES = 4;

  typedef enum logic [1:0] {
    CGC_MODE_SELF = 2'b00,
    CGC_MODE_FEI = 2'b01,
    CGC_MODE_FBE = 2'b10,
    CGC_MODE_FEE = 2'b11
  } cgc_mode_e;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } cgc_req_s;

  typedef struct packed {
    logic high_gain_select;
    logic high_range;
    logic ext_reference_select;
    logic osc_enable;
    logic ext_pin_reserved;
    logic [7:0] prescale;
    logic [4:0] multiply_factor;
    logic [7:0] divide_factor;
  } cgc_cfg_s;

endpackage : cgc_pkg

// file: verilog/cgc_ctrl.sv
// Purpose: Control register pair of an on-chip clock generator
// Assumes: Register port on core_clk_i; loop status arrives from other clocks
// Notes: Mode writes are applied after a settling delay; multiply and divide writes apply at once
// How it works
// - Bit7: low power or high gain
// - Gain, range, reference fields write once
// - Range: prescale 64 low, 1 high
// - Range matters only in external modes
// - Bit5: external clock or crystal
// - Bits4:3 select four clock modes
// - Bypass external waits for stable reference
// - Off mode keeps stored mode field
// - Mode write ignored while previous pending
// - Internal first write blocks external modes
// - Oscillator enable in off mode rules
// - Keep-in-off ignored when gain and range
// - Bit1 disables loss-of-clock detection
// - Lock loss gives interrupt or reset
// - Clock loss gives interrupt or reset
// - Multiply field: factor 4 to 18
// - Multiply write ignored while previous pending
// - Divider field: power of two to 128
// - Divider write ignored while previous pending
// - Stable flag set only when reference fast; here it follows ref_ok_s at either range
// - Lock loss flag sticky until cleared
// - First write decides external pin reservation
`timescale 1ns/1ps
module cgc_ctrl #(
  parameter int UPDATE_CYCLES = cgc_pkg::CGC_UPDATE_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  input wire logic [2:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic off_req_i,
  input wire logic enable_i,
  input wire logic ext_ref_ok_i,
  input wire logic lock_lost_i,
  input wire logic clock_lost_i,
  output logic [1:0] active_mode_o,
  output logic off_mode_o,
  output cgc_pkg::cgc_cfg_s cfg_o,
  output logic irq_req_o,
  output logic rst_req_o
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else begin
      sync1_q <= {off_req_i, ext_ref_ok_i, lock_lost_i, clock_lost_i};
      sync2_q <= sync1_q;
    end
  end
  logic off_s;
  logic ref_ok_s;
  logic lock_lost_s;
  logic clock_lost_s;
  assign {off_s, ref_ok_s, lock_lost_s, clock_lost_s} = sync2_q;

  cgc_pkg::cgc_req_s req;
  assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  function automatic logic hit(input cgc_pkg::cgc_req_s r, input logic [2:0] a);
    hit = r.wr && (r.addr == a);
  endfunction : hit

  logic wr_c1;
  logic wr_c2;
  logic wr_fl;
  assign wr_c1 = hit(req, cgc_pkg::CGC_ADDR_CTRL_ONE);
  assign wr_c2 = hit(req, cgc_pkg::CGC_ADDR_CTRL_TWO);
  assign wr_fl = hit(req, cgc_pkg::CGC_ADDR_FLAGS);

  // ----------------------------------------------------------------
  // Control one
  // ----------------------------------------------------------------
  logic first_done_q;
  logic hgo_q;
  logic range_q;
  logic ext_reference_select_q;
  logic ext_allowed_q;
  logic oscoff_q;
  logic clock_loss_detect_disable_q;
  logic [1:0] mode_q;
  logic [1:0] mode_pend_q;
  logic [$clog2(UPDATE_CYCLES+1)-1:0] mode_cnt_q;
  logic mode_busy;
  logic [1:0] new_mode;
  logic mode_ok;

  assign mode_busy = (mode_cnt_q != '0);
  assign new_mode = wdata_i[cgc_pkg::CGC_C1_MODE_HI:cgc_pkg::CGC_C1_MODE_LO];
  assign mode_ok = !first_done_q || ext_allowed_q || !new_mode[1];

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      first_done_q <= 1'b0;
      hgo_q <= cgc_pkg::CGC_C1_RESET[cgc_pkg::CGC_C1_HGO];
      range_q <= cgc_pkg::CGC_C1_RESET[cgc_pkg::CGC_C1_RANGE];
      ext_reference_select_q <= cgc_pkg::CGC_C1_RESET[cgc_pkg::CGC_C1_REF];
      ext_allowed_q <= 1'b0;
    end else if (wr_c1 && !first_done_q) begin
      first_done_q <= 1'b1;
      hgo_q <= wdata_i[cgc_pkg::CGC_C1_HGO];
      range_q <= wdata_i[cgc_pkg::CGC_C1_RANGE];
      ext_reference_select_q <= wdata_i[cgc_pkg::CGC_C1_REF];
      ext_allowed_q <= new_mode[1];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      oscoff_q <= cgc_pkg::CGC_C1_RESET[cgc_pkg::CGC_C1_OSCOFF];
      clock_loss_detect_disable_q <= cgc_pkg::CGC_C1_RESET[cgc_pkg::CGC_C1_CLOCK_LOSS_DETECT_DISABLE];
    end else if (wr_c1) begin
      oscoff_q <= wdata_i[cgc_pkg::CGC_C1_OSCOFF];
      clock_loss_detect_disable_q <= wdata_i[cgc_pkg::CGC_C1_CLOCK_LOSS_DETECT_DISABLE];
    end
  end

  // Stored field changes only by writes; off mode never touches it
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode_pend_q <= cgc_pkg::CGC_C1_RESET[cgc_pkg::CGC_C1_MODE_HI:cgc_pkg::CGC_C1_MODE_LO];
      mode_cnt_q <= '0;
    end else if (wr_c1 && !mode_busy && mode_ok) begin
      mode_pend_q <= new_mode;
      mode_cnt_q <= ($clog2(UPDATE_CYCLES+1))'(UPDATE_CYCLES);
    end else if (mode_busy) begin
      mode_cnt_q <= mode_cnt_q - 1'b1;
    end
  end

  // Active mode follows the stored field; bypass waits for the reference
  logic mode_go;
  assign mode_go = !mode_busy && !off_s && (mode_q != mode_pend_q) &&
                   ((mode_pend_q != cgc_pkg::CGC_MODE_FBE) || ref_ok_s);
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mode_q <= cgc_pkg::CGC_MODE_SELF;
    end else if (mode_go) begin
      mode_q <= mode_pend_q;
    end
  end

  // ----------------------------------------------------------------
  // Control two
  // ----------------------------------------------------------------
  logic lock_loss_reset_enable_q;
  logic clock_loss_reset_enable_q;
  logic [2:0] mfd_q;
  logic [2:0] rfd_q;
  logic [$clog2(UPDATE_CYCLES+1)-1:0] mfd_cnt_q;
  logic [$clog2(UPDATE_CYCLES+1)-1:0] rfd_cnt_q;

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lock_loss_reset_enable_q <= cgc_pkg::CGC_C2_RESET[cgc_pkg::CGC_C2_LOCK_LOSS_RESET_ENABLE];
      clock_loss_reset_enable_q <= cgc_pkg::CGC_C2_RESET[cgc_pkg::CGC_C2_CLOCK_LOSS_RESET_ENABLE];
    end else if (wr_c2) begin
      lock_loss_reset_enable_q <= wdata_i[cgc_pkg::CGC_C2_LOCK_LOSS_RESET_ENABLE];
      clock_loss_reset_enable_q <= wdata_i[cgc_pkg::CGC_C2_CLOCK_LOSS_RESET_ENABLE];
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mfd_q <= cgc_pkg::CGC_C2_RESET[cgc_pkg::CGC_C2_MFD_HI:cgc_pkg::CGC_C2_MFD_LO];
      mfd_cnt_q <= '0;
    end else if (wr_c2 && mfd_cnt_q == '0) begin
      mfd_q <= wdata_i[cgc_pkg::CGC_C2_MFD_HI:cgc_pkg::CGC_C2_MFD_LO];
      mfd_cnt_q <= ($clog2(UPDATE_CYCLES+1))'(UPDATE_CYCLES);
    end else if (mfd_cnt_q != '0) begin
      mfd_cnt_q <= mfd_cnt_q - 1'b1;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rfd_q <= cgc_pkg::CGC_C2_RESET[cgc_pkg::CGC_C2_RFD_HI:cgc_pkg::CGC_C2_RFD_LO];
      rfd_cnt_q <= '0;
    end else if (wr_c2 && rfd_cnt_q == '0) begin
      rfd_q <= wdata_i[cgc_pkg::CGC_C2_RFD_HI:cgc_pkg::CGC_C2_RFD_LO];
      rfd_cnt_q <= ($clog2(UPDATE_CYCLES+1))'(UPDATE_CYCLES);
    end else if (rfd_cnt_q != '0) begin
      rfd_cnt_q <= rfd_cnt_q - 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Sticky flags and requests
  // ----------------------------------------------------------------
  logic lock_loss_sticky_flag_q;
  logic locs_q;
  logic loc_event;
  assign loc_event = clock_lost_s && !clock_loss_detect_disable_q;
  // Set beats a clear in the same cycle
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      lock_loss_sticky_flag_q <= 1'b0;
      locs_q <= 1'b0;
    end else begin
      lock_loss_sticky_flag_q <= lock_lost_s || (lock_loss_sticky_flag_q && !(wr_fl && wdata_i[cgc_pkg::CGC_FL_LOCK_LOSS_STICKY_FLAG]));
      locs_q <= loc_event || (locs_q && !(wr_fl && wdata_i[cgc_pkg::CGC_FL_LOCS]));
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      irq_req_o <= 1'b0;
      rst_req_o <= 1'b0;
    end else begin
      irq_req_o <= (lock_loss_sticky_flag_q && !lock_loss_reset_enable_q) || (locs_q && !clock_loss_reset_enable_q);
      rst_req_o <= (lock_loss_sticky_flag_q && lock_loss_reset_enable_q) || (locs_q && clock_loss_reset_enable_q);
    end
  end

  // ----------------------------------------------------------------
  // Derived configuration
  // ----------------------------------------------------------------
  logic ext_mode;
  logic osc_en;
  assign ext_mode = mode_q[1];
  always_comb begin
    if (!off_s) begin
      osc_en = ext_mode && ext_reference_select_q;
    end else if (hgo_q && range_q) begin
      osc_en = ext_mode && ext_reference_select_q;
    end else if (oscoff_q) begin
      osc_en = mode_pend_q[1] && ext_reference_select_q;
    end else begin
      osc_en = enable_i && (mode_pend_q == cgc_pkg::CGC_MODE_FBE) && ext_reference_select_q;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cfg_o <= '0;
      active_mode_o <= cgc_pkg::CGC_MODE_SELF;
      off_mode_o <= 1'b0;
    end else begin
      cfg_o.high_gain_select <= hgo_q;
      cfg_o.high_range <= ext_mode && range_q;
      cfg_o.ext_reference_select <= ext_reference_select_q;
      cfg_o.osc_enable <= osc_en;
      cfg_o.ext_pin_reserved <= ext_allowed_q;
      cfg_o.prescale <= (ext_mode && range_q) ? cgc_pkg::CGC_PRESCALE_HIGH
                                              : cgc_pkg::CGC_PRESCALE_LOW;
      cfg_o.multiply_factor <= cgc_pkg::CGC_MULT_BASE + 5'({mfd_q, 1'b0});
      cfg_o.divide_factor <= 8'h01 << rfd_q;
      active_mode_o <= mode_q;
      off_mode_o <= off_s;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      unique case (addr_i)
        cgc_pkg::CGC_ADDR_CTRL_ONE: rdata_o <= {hgo_q, range_q, ext_reference_select_q, mode_pend_q,
                                                oscoff_q, clock_loss_detect_disable_q, 1'b0};
        cgc_pkg::CGC_ADDR_CTRL_TWO: rdata_o <= {lock_loss_reset_enable_q, mfd_q, clock_loss_reset_enable_q, rfd_q};
        cgc_pkg::CGC_ADDR_STATUS: rdata_o <= {mode_q, ext_reference_select_q, lock_loss_sticky_flag_q, 1'b0, locs_q,
                                              ref_ok_s, 1'b0};
        cgc_pkg::CGC_ADDR_FLAGS: rdata_o <= {6'h00, locs_q, lock_loss_sticky_flag_q};
        default: rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_write_once;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      first_done_q |=> $stable(hgo_q) && $stable(range_q) && $stable(ext_reference_select_q);
  endproperty
  a_write_once: assert property (p_write_once) else $error("write-once bit changed");

  property p_bypass_wait;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      (mode_q != cgc_pkg::CGC_MODE_FBE) ##1 (mode_q == cgc_pkg::CGC_MODE_FBE) |->
        $past(ref_ok_s);
  endproperty
  a_bypass_wait: assert property (p_bypass_wait) else $error("bypass without stable ref");

  property p_ext_block;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      first_done_q && !ext_allowed_q |-> !mode_pend_q[1];
  endproperty
  a_ext_block: assert property (p_ext_block) else $error("external mode accepted");

  property p_mode_busy;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      mode_busy |=> $stable(mode_pend_q);
  endproperty
  a_mode_busy: assert property (p_mode_busy) else $error("mode changed while pending");

  property p_mfd_busy;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      (mfd_cnt_q != '0) |=> $stable(mfd_q);
  endproperty
  a_mfd_busy: assert property (p_mfd_busy) else $error("multiply changed while pending");

  property p_rfd_busy;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      (rfd_cnt_q != '0) |=> $stable(rfd_q);
  endproperty
  a_rfd_busy: assert property (p_rfd_busy) else $error("divider changed while pending");

  property p_lock_loss_sticky_flag_sticky;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      lock_loss_sticky_flag_q && !(wr_fl && wdata_i[cgc_pkg::CGC_FL_LOCK_LOSS_STICKY_FLAG]) |=> lock_loss_sticky_flag_q;
  endproperty
  a_lock_loss_sticky_flag_sticky: assert property (p_lock_loss_sticky_flag_sticky) else $error("lock flag dropped");

  property p_lock_req;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      lock_loss_sticky_flag_q |=> (irq_req_o || rst_req_o);
  endproperty
  a_lock_req: assert property (p_lock_req) else $error("no request on lock loss");

  property p_clock_loss_detect_disable;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      clock_loss_detect_disable_q && !locs_q |=> !locs_q;
  endproperty
  a_clock_loss_detect_disable: assert property (p_clock_loss_detect_disable) else $error("clock loss flagged while disabled");

  property p_lock_rst;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      lock_loss_sticky_flag_q && lock_loss_reset_enable_q |=> rst_req_o;
  endproperty
  a_lock_rst: assert property (p_lock_rst) else $error("no reset request on lock loss");

  property p_loss_rst;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      locs_q && clock_loss_reset_enable_q |=> rst_req_o;
  endproperty
  a_loss_rst: assert property (p_loss_rst) else $error("no reset request on clock loss");

  property p_pin_hold;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      first_done_q |=> $stable(ext_allowed_q);
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("pin reservation changed");

  property p_off_field;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      off_s && !wr_c1 |=> $stable(mode_pend_q);
  endproperty
  a_off_field: assert property (p_off_field) else $error("mode field changed in off mode");

  property p_range_int;
    @(posedge core_clk_i) disable iff (!rst_b_i)
      !mode_q[1] |=> (cfg_o.prescale == cgc_pkg::CGC_PRESCALE_LOW);
  endproperty
  a_range_int: assert property (p_range_int) else $error("range used in internal mode");

  c_fbe: cover property (@(posedge core_clk_i) mode_q == cgc_pkg::CGC_MODE_FBE);
  c_fee: cover property (@(posedge core_clk_i) mode_q == cgc_pkg::CGC_MODE_FEE);
  c_rst: cover property (@(posedge core_clk_i) rst_req_o);
  c_off: cover property (@(posedge core_clk_i) off_s && osc_en);

endmodule : cgc_ctrl

// file: verif/cgc_ext_src.sv
// Purpose: Behavioural external reference source facing the clock control block
// Assumes: One clock; reference start-up counted in core clock cycles
// Notes: Start-up time is an input, so the bench can model fast or slow parts
`timescale 1ns/1ps
module cgc_ext_src (
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic run_i,
  input wire logic [7:0] startup_i,
  input wire logic kill_clk_i,
  input wire logic kill_lock_i,
  output logic ext_ref_ok_o,
  output logic clock_lost_o,
  output logic lock_lost_o
);
  // ----------------------------------------------------------------
  // Start-up counter
  // ----------------------------------------------------------------
  logic [7:0] cnt_q;

  // A killed clock restarts the count, as a real crystal would
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cnt_q <= 8'h00;
    end else if (!run_i || kill_clk_i) begin
      cnt_q <= 8'h00;
    end else if (cnt_q != startup_i) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  assign ext_ref_ok_o = run_i && !kill_clk_i && (cnt_q == startup_i);
  assign clock_lost_o = kill_clk_i;
  assign lock_lost_o = kill_lock_i;
endmodule : cgc_ext_src

// file: verif/cgc_ctrl_tb.sv
// Purpose: Self-checking bench for the clock generator control registers
// Assumes: Update delay parameter set to 2 for a shorter run
// Notes: Waits on outputs are bounded; settling latency is not pinned
`timescale 1ns/1ps
module cgc_ctrl_tb;
  logic core_clk, rst_b, wr, rd, off_req, enable, run, kill_clk, kill_lock;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, startup;
  logic [1:0] active_mode;
  logic off_mode, irq_req, rst_req, ext_ok, clk_lost, lock_lost;
  cgc_pkg::cgc_cfg_s cfg;
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;
  // Rows: control two value, multiply factor, divide factor
  logic [7:0] rows [8][3] = '{'{8'h07, 8'h04, 8'h80}, '{8'h16, 8'h06, 8'h40},
    '{8'h25, 8'h08, 8'h20}, '{8'h34, 8'h0a, 8'h10}, '{8'h43, 8'h0c, 8'h08},
    '{8'h52, 8'h0e, 8'h04}, '{8'h61, 8'h10, 8'h02}, '{8'h70, 8'h12, 8'h01}};

  cgc_ctrl #(.UPDATE_CYCLES(2)) dut_u (.core_clk_i(core_clk), .rst_b_i(rst_b), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .off_req_i(off_req),
    .enable_i(enable), .ext_ref_ok_i(ext_ok), .lock_lost_i(lock_lost),
    .clock_lost_i(clk_lost), .active_mode_o(active_mode), .off_mode_o(off_mode),
    .cfg_o(cfg), .irq_req_o(irq_req), .rst_req_o(rst_req));

  cgc_ext_src src_u (.clk_i(core_clk), .rst_b_i(rst_b), .run_i(run), .startup_i(startup),
    .kill_clk_i(kill_clk), .kill_lock_i(kill_lock), .ext_ref_ok_o(ext_ok),
    .clock_lost_o(clk_lost), .lock_lost_o(lock_lost));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    if (n_fail == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("Error %s expected %h seen %h", name, exp, got);
      n_fail++;
    end
  endtask : chk

  // Idle cycle after each access keeps strobes from being driven twice per step
  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge core_clk);
    wr <= 1'b0;
    @(posedge core_clk);
  endtask : wr_reg

  task automatic wr2(input logic [2:0] a, input logic [7:0] d1, input logic [7:0] d2);
    wr <= 1'b1;
    addr <= a;
    wdata <= d1;
    @(posedge core_clk);
    wdata <= d2;
    @(posedge core_clk);
    wr <= 1'b0;
    @(posedge core_clk);
  endtask : wr2

  task automatic rd_chk(input logic [2:0] a, input logic [7:0] exp);
    rd <= 1'b1;
    addr <= a;
    @(posedge core_clk);
    rd <= 1'b0;
    @(negedge core_clk);
    chk("rdata", exp, rdata);
    @(posedge core_clk);
  endtask : rd_chk

  task automatic wait_mode(input logic [1:0] exp);
    @(negedge core_clk);
    for (int i = 0; i < 80 && active_mode !== exp; i++) @(negedge core_clk);
    chk("active_mode", {6'h00, exp}, {6'h00, active_mode});
    @(posedge core_clk);
  endtask : wait_mode

  task automatic wait_req(input logic [1:0] exp);
    @(negedge core_clk);
    for (int i = 0; i < 20 && {rst_req, irq_req} !== exp; i++) @(negedge core_clk);
    chk("requests", {6'h00, exp}, {6'h00, rst_req, irq_req});
    @(posedge core_clk);
  endtask : wait_req

  task automatic wait_cfg(input logic [7:0] m, input logic [7:0] d);
    @(negedge core_clk);
    for (int i = 0; i < 40 && cfg.multiply_factor !== m[4:0]; i++) @(negedge core_clk);
    chk("multiply", m, {3'h0, cfg.multiply_factor});
    chk("divide", d, cfg.divide_factor);
    @(posedge core_clk);
  endtask : wait_cfg

  task automatic pulse(input logic clk_kind);
    if (clk_kind) kill_clk <= 1'b1;
    else kill_lock <= 1'b1;
    repeat (4) @(posedge core_clk);
    kill_clk <= 1'b0;
    kill_lock <= 1'b0;
    @(posedge core_clk);
  endtask : pulse

  task automatic do_reset();
    rst_b <= 1'b0;
    repeat (16) @(posedge core_clk);
    rst_b <= 1'b1;
    @(posedge core_clk);
  endtask : do_reset

  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_b = 1'b0;
    {wr, rd, off_req, enable, run, kill_clk, kill_lock} = 7'h00;
    addr = 3'h0;
    wdata = 8'h00;
    startup = 8'h28;
    do_reset();
    wait_cfg(8'h04, 8'h01);
    chk("prescale", 8'h40, cfg.prescale);
    rd_chk(cgc_pkg::CGC_ADDR_CTRL_ONE, 8'h00);
    rd_chk(3'h5, 8'h00);
    for (int i = 0; i < 8; i++) begin
      wr_reg(cgc_pkg::CGC_ADDR_CTRL_TWO, rows[i][0]);
      wait_cfg(rows[i][1], rows[i][2]);
      rd_chk(cgc_pkg::CGC_ADDR_CTRL_TWO, rows[i][0]);
    end
    wr2(cgc_pkg::CGC_ADDR_CTRL_TWO, 8'h07, 8'h70);
    repeat (12) @(posedge core_clk);
    wait_cfg(8'h04, 8'h80);
    rd_chk(cgc_pkg::CGC_ADDR_CTRL_TWO, 8'h07);
    // Slow reference: bypass must wait for the stable flag
    run <= 1'b1;
    wr_reg(cgc_pkg::CGC_ADDR_CTRL_ONE, 8'hf0);
    repeat (15) @(posedge core_clk);
    chk("early_mode", 8'h00, {6'h00, active_mode});
    rd_chk(cgc_pkg::CGC_ADDR_STATUS, 8'h20);
    chk("pin_reserved", 8'h01, {7'h00, cfg.ext_pin_reserved});
    chk("high_gain", 8'h01, {7'h00, cfg.high_gain_select});
    wait_mode(2'b10);
    chk("prescale", 8'h01, cfg.prescale);
    chk("high_range", 8'h01, {7'h00, cfg.high_range});
    rd_chk(cgc_pkg::CGC_ADDR_STATUS, 8'ha2);
    wr_reg(cgc_pkg::CGC_ADDR_CTRL_ONE, 8'h18);
    wait_mode(2'b11);
    rd_chk(cgc_pkg::CGC_ADDR_CTRL_ONE, 8'hf8);
    chk("ext_ref", 8'h01, {7'h00, cfg.ext_reference_select});
    chk("osc_enable", 8'h01, {7'h00, cfg.osc_enable});
    wr2(cgc_pkg::CGC_ADDR_CTRL_ONE, 8'he8, 8'he0);
    repeat (12) @(posedge core_clk);
    wait_mode(2'b01);
    rd_chk(cgc_pkg::CGC_ADDR_CTRL_ONE, 8'he8);
    chk("high_range", 8'h00, {7'h00, cfg.high_range});
    off_req <= 1'b1;
    repeat (6) @(posedge core_clk);
    chk("off_mode", 8'h01, {7'h00, off_mode});
    chk("osc_enable", 8'h00, {7'h00, cfg.osc_enable});
    rd_chk(cgc_pkg::CGC_ADDR_CTRL_ONE, 8'he8);
    off_req <= 1'b0;
    // Internal first write locks out external modes
    do_reset();
    wr_reg(cgc_pkg::CGC_ADDR_CTRL_ONE, 8'h26);
    repeat (8) @(posedge core_clk);
    wr_reg(cgc_pkg::CGC_ADDR_CTRL_ONE, 8'h1e);
    repeat (20) @(posedge core_clk);
    rd_chk(cgc_pkg::CGC_ADDR_CTRL_ONE, 8'h26);
    chk("mode", 8'h00, {6'h00, active_mode});
    chk("pin_reserved", 8'h00, {7'h00, cfg.ext_pin_reserved});
    pulse(1'b1);
    repeat (10) @(posedge core_clk);
    chk("requests", 8'h00, {6'h00, rst_req, irq_req});
    wr_reg(cgc_pkg::CGC_ADDR_CTRL_ONE, 8'h24);
    pulse(1'b1);
    wait_req(2'b01);
    wr_reg(cgc_pkg::CGC_ADDR_FLAGS, 8'h02);
    wait_req(2'b00);
    wr_reg(cgc_pkg::CGC_ADDR_CTRL_TWO, 8'h08);
    pulse(1'b1);
    wait_req(2'b10);
    wr_reg(cgc_pkg::CGC_ADDR_FLAGS, 8'h02);
    wait_req(2'b00);
    pulse(1'b0);
    repeat (10) @(posedge core_clk);
    wait_req(2'b01);
    rd_chk(cgc_pkg::CGC_ADDR_FLAGS, 8'h01);
    wr_reg(cgc_pkg::CGC_ADDR_FLAGS, 8'h01);
    wait_req(2'b00);
    wr_reg(cgc_pkg::CGC_ADDR_CTRL_TWO, 8'h80);
    pulse(1'b0);
    wait_req(2'b10);
    wr_reg(cgc_pkg::CGC_ADDR_CTRL_TWO, 8'h00);
    repeat (8) @(posedge core_clk);
    wait_req(2'b01);
    tally_and_finish();
  end
endmodule : cgc_ctrl_tb
